// File: logic/core_interrupt_enable_flags.sv
// Purpose : interrupt control register, peripheral enable one register and core request logic
// Assumes : inputs synchronous to i_clk; per-pin change flags and peripheral flags live outside
// Notes   : reads take one wait state, writes none; response always OKAY
// Notes on behaviour
// RULE_01 - global enable bit 7 gates every request
// RULE_02 - peripheral group enable bit 6 gates peripherals
// RULE_03 - timer zero enable bit 5, flag bit 2
// RULE_04 - external pin enable bit 4, flag bit 1
// RULE_05 - pin change enable bit 3 gates change requests
// RULE_06 - summary flag bit 0 follows per-pin flags
// RULE_07 - summary flag read-only, clears with per-pin flags
// RULE_08 - flags set regardless of any enable
// RULE_09 - software clears flags before enabling them
// RULE_10 - peripheral enables need group enable too
// RULE_11 - bit 7 gate acquisition, bit 6 adc
// RULE_12 - bit 5 serial receive, bit 4 transmit
// RULE_13 - bit 3 sync port, bit 2 capcomp
// RULE_14 - bit 1 timer two match, bit 0 overflow
// RULE_15 - both registers reset to zero
// RULE_16 - taking interrupt clears global enable, loads vector
// RULE_17 - return from interrupt sets global enable again
// RULE_18 - edge select picks rising or falling pin edge
// RULE_19 - request combines core and gated peripheral terms
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module core_interrupt_enable_flags #(
  parameter int PIN_COUNT = 8
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire irq_ctrl_pkg::ahb_in_t  i_ahb,
  output logic [31:0]                 o_hrdata,
  output logic                        o_hreadyout,
  output logic                        o_hresp,
  input  wire logic                   i_timer_zero_overflow,
  input  wire logic                   i_ext_pin,
  input  wire logic                   i_ext_edge_select,
  input  wire logic [PIN_COUNT-1:0]   i_per_pin_change_flags,
  input  wire logic [7:0]             i_periph_flags,
  input  wire logic                   i_return_from_irq,
  output logic                        o_core_irq_req,
  output logic                        o_irq_take,
  output logic [13:0]                 o_vector_addr,
  output logic                        o_irq_return,
  output logic                        o_irq
);
  import irq_ctrl_pkg::*;

  // whole module state
  typedef struct packed {
    bus_state_t          bus;
    logic [7:0]          addr;
    logic [31:0]         rdata;
    logic                ready;
    logic [7:0]          ctrl;
    logic [7:0]          periph_en;
    logic                ext_pin_prev;
    logic                req;
    logic                take;
    logic [13:0]         vector;
    logic                ret;
    logic [EVT_COUNT-1:0] evt_stat;
    logic [EVT_COUNT-1:0] evt_en;
    logic                irq;
  } state_t;

  state_t st_q;
  state_t st_d;

  // one-hot register select, shared by the read and write paths
  function automatic logic [4:0] reg_sel(input logic [7:0] a);
    logic [4:0] s;
    s = 5'h00;
    case (a)
      OFF_CTRL:     s = 5'h01;
      OFF_PERIPH_EN: s = 5'h02;
      OFF_EVT_STAT: s = 5'h04;
      OFF_EVT_CLR:  s = 5'h08;
      OFF_EVT_EN:   s = 5'h10;
      default:      s = 5'h00;
    endcase
    return s;
  endfunction : reg_sel

  logic                  accept;
  logic                  core_term;
  logic                  periph_term;
  logic                  req_calc;
  logic                  ext_rise;
  logic                  ext_fall;
  logic                  ext_edge;
  logic                  take_next;
  logic [4:0]            wsel;
  logic [4:0]            rsel;
  logic [7:0]            wbyte;
  logic [EVT_COUNT-1:0]  evt_set;

  // address phase is taken only when the bus is ready
  assign accept = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;
  assign wsel   = (st_q.bus == BUS_WRITE) ? reg_sel(st_q.addr) : 5'h00;
  assign rsel   = reg_sel(st_q.addr);
  assign wbyte  = i_ahb.hwdata[7:0];

  // external pin edge, chosen by edge select
  assign ext_rise = i_ext_pin & ~st_q.ext_pin_prev;
  assign ext_fall = ~i_ext_pin & st_q.ext_pin_prev;
  assign ext_edge = i_ext_edge_select ? ext_rise : ext_fall; // RULE_18

  // request terms; core sources need their own enable, peripherals also the group enable
  assign core_term = (st_q.ctrl[BIT_T0_EN] & st_q.ctrl[BIT_T0_FLAG])       // RULE_03
                   | (st_q.ctrl[BIT_EXT_EN] & st_q.ctrl[BIT_EXT_FLAG])     // RULE_04
                   | (st_q.ctrl[BIT_CHANGE_EN] & st_q.ctrl[BIT_CHANGE_FLAG]); // RULE_05
  assign periph_term = st_q.ctrl[BIT_PERIPH_EN] & (|(st_q.periph_en & i_periph_flags)); // RULE_02 RULE_10
  assign req_calc = st_q.ctrl[BIT_GLOBAL_EN] & (core_term | periph_term); // RULE_01 RULE_19

  // block events for the local interrupt output
  // take decided from registered state only, so the status path forms no loop through st_d
  assign take_next = st_q.req & st_q.ctrl[BIT_GLOBAL_EN] & ~st_q.take;
  assign evt_set = {ext_edge, i_return_from_irq, take_next};

  // next state
  always_comb begin
    st_d = st_q;
    st_d.ext_pin_prev = i_ext_pin;

    // bus data phase
    case (st_q.bus)
      BUS_IDLE: begin
        st_d.ready = 1'b1;
      end
      BUS_WRITE: begin
        st_d.ready = 1'b1;
      end
      BUS_READ: begin
        // registers sampled one cycle late so a preceding write is already applied
        st_d.rdata = 32'h0000_0000;
        case (1'b1)
          rsel[0]: st_d.rdata = {24'h00_0000, st_q.ctrl};
          rsel[1]: st_d.rdata = {24'h00_0000, st_q.periph_en};
          rsel[2]: st_d.rdata = {29'h0000_0000, st_q.evt_stat};
          rsel[4]: st_d.rdata = {29'h0000_0000, st_q.evt_en};
          default: st_d.rdata = 32'h0000_0000;
        endcase
        st_d.ready = 1'b1;
      end
      default: begin
        st_d.ready = 1'b1;
      end
    endcase
    st_d.bus = BUS_IDLE;
    if (accept) begin
      st_d.addr = {i_ahb.haddr[7:2], 2'b00};
      if (i_ahb.hwrite) begin
        st_d.bus = BUS_WRITE;
      end else begin
        st_d.bus   = BUS_READ;
        st_d.ready = 1'b0;
      end
    end

    // software writes to the control register; the summary bit is not writable
    if (wsel[0]) begin
      st_d.ctrl[7:1] = wbyte[7:1];
    end
    st_d.ctrl[BIT_CHANGE_FLAG] = |i_per_pin_change_flags; // RULE_06 RULE_07
    // hardware set wins over a software clear in the same cycle
    st_d.ctrl[BIT_T0_FLAG]  = st_d.ctrl[BIT_T0_FLAG] | i_timer_zero_overflow; // RULE_03 RULE_08
    st_d.ctrl[BIT_EXT_FLAG] = st_d.ctrl[BIT_EXT_FLAG] | ext_edge; // RULE_04 RULE_08
    if (wsel[1]) begin
      st_d.periph_en = wbyte; // RULE_11 RULE_12 RULE_13 RULE_14
    end

    // vectoring: one take pulse, global enable dropped so it cannot repeat
    st_d.req  = req_calc;
    st_d.take = take_next;
    if (st_d.take) begin
      st_d.ctrl[BIT_GLOBAL_EN] = 1'b0; // RULE_16
      st_d.vector = IRQ_VECTOR; // RULE_16
      st_d.req = 1'b0;
    end
    // return re-enables last, so it beats a take or write in the same cycle
    st_d.ret = i_return_from_irq;
    if (i_return_from_irq) begin
      st_d.ctrl[BIT_GLOBAL_EN] = 1'b1; // RULE_17
    end

    // block event status, set beats write-one-to-clear
    if (wsel[3]) begin
      st_d.evt_stat = st_q.evt_stat & ~wbyte[EVT_COUNT-1:0];
    end
    st_d.evt_stat = st_d.evt_stat | evt_set;
    if (wsel[4]) begin
      st_d.evt_en = wbyte[EVT_COUNT-1:0];
    end
    st_d.irq = |(st_q.evt_stat & st_q.evt_en);
  end

  // state register; everything clears to zero on reset except ready, which resets high, and bus, which resets to BUS_IDLE
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q.bus          <= BUS_IDLE;
      st_q.addr         <= 8'h00;
      st_q.rdata        <= 32'h0000_0000;
      st_q.ready        <= 1'b1;
      st_q.ctrl         <= RST_CTRL; // RULE_15
      st_q.periph_en    <= RST_PERIPH_EN; // RULE_15
      st_q.ext_pin_prev <= 1'b0;
      st_q.req          <= 1'b0;
      st_q.take         <= 1'b0;
      st_q.vector       <= RST_VECTOR;
      st_q.ret          <= 1'b0;
      st_q.evt_stat     <= RST_EVT;
      st_q.evt_en       <= RST_EVT;
      st_q.irq          <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state, except o_hresp which is tied to OKAY
  assign o_hrdata       = st_q.rdata;
  assign o_hreadyout    = st_q.ready;
  assign o_hresp        = 1'b0;
  assign o_core_irq_req = st_q.req;
  assign o_irq_take     = st_q.take;
  assign o_vector_addr  = st_q.vector;
  assign o_irq_return   = st_q.ret;
  assign o_irq          = st_q.irq;

  // checks on the request path, flags, bus port and event status
  a_no_req_gie_off: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_01
    !st_q.ctrl[BIT_GLOBAL_EN] |=> !o_core_irq_req)
    else $error("request raised while global enable clear");

  a_periph_gated: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_10
    (st_q.ctrl[BIT_GLOBAL_EN] && !st_q.ctrl[BIT_PERIPH_EN] && !core_term && !st_d.take)
      |=> !o_core_irq_req)
    else $error("peripheral request passed without group enable");

  a_req_formula: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_19
    !st_d.take |=> (o_core_irq_req == $past(req_calc)))
    else $error("core request does not match enables and flags");

  a_timer_flag_set: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_08
    i_timer_zero_overflow |=> st_q.ctrl[BIT_T0_FLAG])
    else $error("timer zero flag not set after overflow");

  a_ext_edge_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_18
    ((i_ext_edge_select && i_ext_pin && !st_q.ext_pin_prev) ||
     (!i_ext_edge_select && !i_ext_pin && st_q.ext_pin_prev)) |=> st_q.ctrl[BIT_EXT_FLAG])
    else $error("external flag missed a selected edge");

  a_summary_track: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_07
    ##1 (st_q.ctrl[BIT_CHANGE_FLAG] == $past(|i_per_pin_change_flags)))
    else $error("change summary flag differs from per-pin flags");

  a_take_clears_gie: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_16
    $rose(o_irq_take) && !$past(i_return_from_irq)
      |-> !st_q.ctrl[BIT_GLOBAL_EN] && o_vector_addr == IRQ_VECTOR ##1 !o_irq_take)
    else $error("take did not clear global enable or load vector");

  a_return_sets_gie: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_17
    i_return_from_irq |=> st_q.ctrl[BIT_GLOBAL_EN] && o_irq_return)
    else $error("return did not set global enable");

  a_read_wait: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (accept && !i_ahb.hwrite) |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read data phase not exactly one wait state");

  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ##1 (o_irq == $past(|(st_q.evt_stat & st_q.evt_en))))
    else $error("interrupt output disagrees with enabled status");

  a_hresp_okay: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_hresp == 1'b0)
    else $error("bus response not okay");

  a_write_no_wait: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (accept && i_ahb.hwrite) |=> o_hreadyout)
    else $error("write data phase stalled");

  a_rdata_upper: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_take_single: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_16
    o_irq_take |=> !o_irq_take)
    else $error("take pulse longer than one cycle");

  a_take_needs_req: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_16
    $rose(o_irq_take) |-> $past(o_core_irq_req) && $past(st_q.ctrl[BIT_GLOBAL_EN]))
    else $error("take without request and global enable");

  a_req_drops_take: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_16
    o_irq_take |-> !o_core_irq_req)
    else $error("request still high during take");

  a_vector_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_16
    (o_vector_addr == IRQ_VECTOR) |=> (o_vector_addr == IRQ_VECTOR))
    else $error("vector address changed after first take");

  a_return_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_17
    ##1 (o_irq_return == $past(i_return_from_irq)))
    else $error("return pulse does not follow core return");

  a_ext_flag_held: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_04
    (!wsel[0] && st_q.ctrl[BIT_EXT_FLAG]) |=> st_q.ctrl[BIT_EXT_FLAG])
    else $error("external flag lost without a write");

  a_t0_flag_held: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_03
    (!wsel[0] && st_q.ctrl[BIT_T0_FLAG]) |=> st_q.ctrl[BIT_T0_FLAG])
    else $error("timer zero flag lost without a write");

  a_enables_held: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_05
    !wsel[0] |=> $stable(st_q.ctrl[5:3]))
    else $error("source enables changed without a write");

  a_periph_held: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_11
    !wsel[1] |=> $stable(st_q.periph_en))
    else $error("peripheral enables changed without a write");

  a_periph_write: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_12 RULE_13 RULE_14
    wsel[1] |=> (st_q.periph_en == $past(wbyte)))
    else $error("peripheral enable write not stored");

  a_periph_req: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_02
    (st_q.ctrl[BIT_GLOBAL_EN] && periph_term && !take_next) |=> o_core_irq_req)
    else $error("enabled peripheral flag raised no request");

  a_change_gated: assert property (@(posedge i_clk) disable iff (!i_arst_n) // RULE_05
    (!st_q.ctrl[BIT_CHANGE_EN] && !(st_q.ctrl[BIT_T0_EN] && st_q.ctrl[BIT_T0_FLAG]) &&
     !(st_q.ctrl[BIT_EXT_EN] && st_q.ctrl[BIT_EXT_FLAG]) && !periph_term) |=> !o_core_irq_req)
    else $error("pin change request passed while disabled");

  a_evt_sticky: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !wsel[3] |=> ((st_q.evt_stat & $past(st_q.evt_stat)) == $past(st_q.evt_stat)))
    else $error("event status bit lost without a clear");

  a_irq_masked: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (st_q.evt_en == RST_EVT) |=> !o_irq)
    else $error("interrupt output high with all events masked");

endmodule : core_interrupt_enable_flags

// File: logic/irq_ctrl_pkg.sv
// Purpose : shared constants and types for the core interrupt enable and flag block
// Assumes : AHB-Lite register access, one 20 MHz clock
// Notes   : register offsets are byte addresses of aligned 32-bit words
package irq_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_PERIPH_EN = 8'h04;
  localparam logic [7:0] OFF_EVT_STAT = 8'h08;
  localparam logic [7:0] OFF_EVT_CLR  = 8'h0c;
  localparam logic [7:0] OFF_EVT_EN   = 8'h10;

  // interrupt control field positions
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_PERIPH_EN   = 6;
  localparam int BIT_T0_EN       = 5;
  localparam int BIT_EXT_EN      = 4;
  localparam int BIT_CHANGE_EN   = 3;
  localparam int BIT_T0_FLAG     = 2;
  localparam int BIT_EXT_FLAG    = 1;
  localparam int BIT_CHANGE_FLAG = 0;

  // peripheral enable one field positions
  localparam int BIT_T1_GATE_EN  = 7;
  localparam int BIT_ADC_EN      = 6;
  localparam int BIT_RX_EN       = 5;
  localparam int BIT_TX_EN       = 4;
  localparam int BIT_SYNC_EN     = 3;
  localparam int BIT_CAPCOMP_EN  = 2;
  localparam int BIT_T2_MATCH_EN = 1;
  localparam int BIT_T1_OVF_EN   = 0;

  // block event status bits
  localparam int EVT_TAKE     = 0;
  localparam int EVT_RETURN   = 1;
  localparam int EVT_EXT_EDGE = 2;
  localparam int EVT_COUNT    = 3;

  // values after reset, and the vector address loaded on a take
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [7:0]  RST_PERIPH_EN = 8'h00;
  localparam logic [2:0]  RST_EVT    = 3'h0;
  localparam logic [13:0] RST_VECTOR = 14'h0000;
  localparam logic [13:0] IRQ_VECTOR = 14'h0004;

  // bus data phase states
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ  = 3'b100
  } bus_state_t;

  // ahb-lite request signals from master and decoder
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_in_t;

endpackage : irq_ctrl_pkg

// File: test/core_interrupt_enable_flags_tb.sv
// Purpose : self-checking bench for the interrupt enable and flag block
// Assumes : 20 MHz clock; ahb-lite single word transfers
// Notes   : outputs sampled at the falling edge to avoid edge races
`timescale 1ns/1ps
module core_interrupt_enable_flags_tb;
  import irq_ctrl_pkg::*;
  logic        i_clk, i_arst_n, sel, wr, rdy_n, esel, hready, hresp, req, take, ret_o, irq, t0, pin, ret;
  logic [1:0]  trans;
  logic [31:0] addr, wdata, rd_n, hrdata, r;
  logic [7:0]  chg, per;
  logic [13:0] vec;
  ahb_in_t     bus;
  int          failures, tests_run, cyc, ctrl_m, k, n_take, n_req, n_ret;
  assign bus = {sel, addr, trans, wr, 3'h2, wdata, hready};
  core_interrupt_enable_flags u_core_interrupt_enable_flags (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ahb(bus),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_timer_zero_overflow(t0), .i_ext_pin(pin),
    .i_ext_edge_select(esel), .i_per_pin_change_flags(chg), .i_periph_flags(per), .i_return_from_irq(ret),
    .o_core_irq_req(req), .o_irq_take(take), .o_vector_addr(vec), .o_irq_return(ret_o), .o_irq(irq));
  event_src_model u_event_src_model (.i_clk(i_clk), .o_t0(t0), .o_pin(pin), .o_chg(chg), .o_per(per), .o_ret(ret));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // mid-cycle copies: what the master sees at the next rising edge
  always @(negedge i_clk) begin
    rdy_n <= hready;
    rd_n <= hrdata;
  end
  // pulse counters for the core link outputs, settled mid-cycle
  always @(negedge i_clk) begin
    if (take === 1'b1) n_take++;
    if (req === 1'b1) n_req++;
    if (ret_o === 1'b1) n_ret++;
  end
  // watchdog; the whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk_sig(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk_sig
  // address phase held until hready, then data phase until hready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge i_clk);
    sel <= 1'b1;
    addr <= {24'h0, a};
    trans <= 2'b10;
    wr <= w;
    @(posedge i_clk);
    while (rdy_n !== 1'b1) @(posedge i_clk);
    sel <= 1'b0;
    trans <= 2'b00;
    wdata <= {24'h0, d};
    @(posedge i_clk);
    while (rdy_n !== 1'b1) @(posedge i_clk);
    r = rd_n;
  endtask : xfer
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk_sig($sformatf("reg %h", a), {24'h0, e}, r);
  endtask : chk_reg
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle
  initial begin
    {sel, wr, esel, rdy_n} = 4'h0;
    trans = 2'b00;
    addr = 32'h0;
    wdata = 32'h0;
    rd_n = 32'h0;
    i_arst_n = 1'b0;
    void'($urandom(32'h147a3b45));
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    chk_reg(OFF_CTRL, 8'h00);
    chk_reg(OFF_PERIPH_EN, 8'h00);
    chk_sig("hresp", 32'h0, {31'h0, hresp});
    // walk a one through every peripheral enable
    for (k = 0; k < 8; k++) begin
      xfer(OFF_PERIPH_EN, 1'b1, 8'(1 << k));
      chk_reg(OFF_PERIPH_EN, 8'(1 << k));
    end
    xfer(OFF_CTRL, 1'b1, 8'h7f);
    chk_reg(OFF_CTRL, 8'h7e);
    settle(2);
    chk_sig("req", 32'h0, {31'h0, req});
    xfer(OFF_CTRL, 1'b1, 8'h00);
    // flags with every control register enable clear
    esel <= 1'b1;
    u_event_src_model.pulse(0, 0);
    u_event_src_model.lv(1'b1, 8'h00, 8'h00);
    chk_reg(OFF_CTRL, 8'h06);
    xfer(OFF_CTRL, 1'b1, 8'h00);
    u_event_src_model.lv(1'b0, 8'h00, 8'h00);
    chk_reg(OFF_CTRL, 8'h00);
    esel <= 1'b0;
    u_event_src_model.lv(1'b1, 8'h00, 8'h00);
    u_event_src_model.lv(1'b0, 8'h10, 8'h00);
    chk_reg(OFF_CTRL, 8'h03);
    xfer(OFF_CTRL, 1'b1, 8'h00);
    chk_reg(OFF_CTRL, 8'h01);
    u_event_src_model.lv(1'b0, 8'h00, 8'h00);
    chk_reg(OFF_CTRL, 8'h00);
    // take on timer zero, event interrupt raised, masked, cleared
    xfer(OFF_EVT_CLR, 1'b1, 8'h07);
    xfer(OFF_EVT_EN, 1'b1, 8'h01);
    u_event_src_model.pulse(0, 0);
    ctrl_m = 8'ha4;
    xfer(OFF_CTRL, 1'b1, 8'(ctrl_m));
    settle(4);
    chk_sig("vector", 32'h4, {18'h0, vec});
    chk_sig("irq", 32'h1, {31'h0, irq});
    chk_reg(OFF_CTRL, 8'(ctrl_m & 8'h7f));
    chk_reg(OFF_EVT_STAT, 8'h01);
    xfer(OFF_EVT_EN, 1'b1, 8'h00);
    settle(2);
    chk_sig("irq", 32'h0, {31'h0, irq});
    xfer(OFF_EVT_EN, 1'b1, 8'h01);
    xfer(OFF_EVT_CLR, 1'b1, 8'h01);
    settle(2);
    chk_sig("irq", 32'h0, {31'h0, irq});
    xfer(OFF_CTRL, 1'b1, 8'h20);
    u_event_src_model.pulse(1, 20);
    chk_reg(OFF_CTRL, 8'ha0);
    // peripheral path needs source enable and group enable
    k = $urandom % 8;
    xfer(OFF_PERIPH_EN, 1'b1, 8'(1 << k));
    xfer(OFF_CTRL, 1'b1, 8'he0);
    u_event_src_model.lv(1'b0, 8'h00, ~8'(1 << k));
    settle(1);
    chk_sig("req", 32'h0, {31'h0, req});
    xfer(OFF_CTRL, 1'b1, 8'ha0);
    u_event_src_model.lv(1'b0, 8'h00, 8'hff);
    settle(1);
    chk_sig("req", 32'h0, {31'h0, req});
    xfer(OFF_CTRL, 1'b1, 8'he0);
    settle(4);
    chk_reg(OFF_CTRL, 8'h60);
    // pin change request path
    u_event_src_model.pulse(1, 0);
    u_event_src_model.lv(1'b0, 8'h01, 8'h00);
    xfer(OFF_CTRL, 1'b1, 8'h88);
    settle(4);
    chk_reg(OFF_CTRL, 8'h09);
    // four takes: timer, peripheral, peripheral after return, pin change
    chk_sig("take count", 32'd4, 32'(n_take));
    chk_sig("req count", 32'd4, 32'(n_req));
    chk_sig("return count", 32'd2, 32'(n_ret));
    end_sim();
  end
endmodule : core_interrupt_enable_flags_tb

// File: test/event_src_model.sv
// Purpose : model of the processor core and peripheral event sources
// Assumes : one clock; every change lands just after a rising edge
// Notes   : return may come prompt (n=0) or slow (large n)
`timescale 1ns/1ps
module event_src_model (
  input  wire logic       i_clk,
  output logic            o_t0,
  output logic            o_pin,
  output logic [7:0]      o_chg,
  output logic [7:0]      o_per,
  output logic            o_ret
);
  // idle sources at time zero
  initial begin
    o_t0 = 1'b0;
    o_pin = 1'b0;
    o_chg = 8'h00;
    o_per = 8'h00;
    o_ret = 1'b0;
  end
  // one-cycle pulse: 0 timer overflow, 1 core return
  task automatic pulse(input int which, input int n);
    repeat (n + 1) @(posedge i_clk);
    if (which == 0) o_t0 <= 1'b1;
    else o_ret <= 1'b1;
    @(posedge i_clk);
    o_t0 <= 1'b0;
    o_ret <= 1'b0;
  endtask : pulse
  // level sources, then two edges so flags have landed
  task automatic lv(input logic p, input logic [7:0] c, input logic [7:0] f);
    @(posedge i_clk);
    o_pin <= p;
    o_chg <= c;
    o_per <= f;
    repeat (2) @(posedge i_clk);
  endtask : lv
endmodule : event_src_model
